// ===== hbwu_pkg.sv
// Package for the hardware breakpoint and watchpoint unit.
// Assumes a register port whose offsets are register indices.
package hbwu_pkg;
   // ==========================================================
   // Register indices (word address = index)
   localparam logic [7:0] REG_IBRK_TARGET = 8'h30;
   localparam logic [7:0] REG_IBRK_CTRL = 8'h40;
   localparam logic [7:0] REG_DW_ADDR_A = 8'h50;
   localparam logic [7:0] REG_DW_ADDR_B = 8'h60;
   localparam logic [7:0] REG_DW_CTRL = 8'h70;
   localparam logic [7:0] REG_RW_MASK = 8'h80;
   localparam logic [7:0] REG_RW_VALUE = 8'h90;
   localparam logic [7:0] REG_RW_CTRL = 8'h9c;
   localparam logic [7:0] REG_INT_TYPE = 8'h15;
   localparam logic [7:0] REG_INT_DATA = 8'h16;
   localparam logic [7:0] REG_IRQ_STATUS = 8'hc0;
   localparam logic [7:0] REG_IRQ_MASK = 8'hc1;
   // ==========================================================
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SEL_BIT = 1;
   localparam int CTRL_LOAD_BIT = 2;
   localparam int CTRL_THR_LSB = 16;
   localparam logic [31:0] IB_CTRL_MASK = 32'h00ff0003;
   localparam logic [31:0] DW_CTRL_MASK = 32'h00ff0007;
   localparam logic [31:0] RW_CTRL_MASK = 32'h00ff0003;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   // ==========================================================
   // Cause codes and status bits
   localparam logic [2:0] CAUSE_IBRK = 3'h3;
   localparam logic [2:0] CAUSE_DW = 3'h4;
   localparam logic [2:0] CAUSE_RW = 3'h5;
   localparam int IRQ_IBRK_BIT = 0;
   localparam int IRQ_DW_BIT = 1;
   localparam int IRQ_RW_BIT = 2;
endpackage

// ===== hbwu_top.sv
// Breakpoint, data watchpoint and resource watchpoint match unit.
// Assumes the pipeline presents one qualified access per cycle.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module hbwu_top
   import hbwu_pkg::*;
(
   input wire logic SYS_CLK, // Core clock
   input wire logic RESET, // Synchronous reset, high
   input wire logic [7:0] REG_ADDR, // Register index
   input wire logic [31:0] REG_WDATA, // Write data
   input wire logic REG_WR, // Write strobe
   input wire logic REG_RD, // Read strobe
   output logic [31:0] REG_RDATA, // Read data, cycle after strobe
   input wire logic PC_VALID, // Instruction issued
   input wire logic [31:0] PC, // Program counter
   input wire logic [2:0] PC_THREAD, // Issuing thread
   input wire logic MEM_VALID, // Memory access
   input wire logic MEM_LOAD, // Access is a load
   input wire logic [31:0] MEM_ADDR, // Effective address
   input wire logic [2:0] MEM_THREAD, // Accessing thread
   input wire logic RES_VALID, // Resource access
   input wire logic [31:0] RES_ID, // Resource identifier
   input wire logic [2:0] RES_THREAD, // Accessing thread
   output logic DEBUG_IRQ // Level, unmasked status set
);
   // ==========================================================
   // Storage
   logic [31:0] ib_target [4];
   logic [31:0] ib_ctrl [4];
   logic [31:0] dw_addr_a [4];
   logic [31:0] dw_addr_b [4];
   logic [31:0] dw_ctrl [4];
   logic [31:0] rw_mask [4];
   logic [31:0] rw_value [4];
   logic [31:0] rw_ctrl [4];
   logic [31:0] int_type;
   logic [31:0] int_data;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [3:0] ib_hit, dw_hit, rw_hit;

   // ==========================================================
   // Comparators, one per index
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_cmp
         wire ib_eq = (PC == ib_target[g]);
         wire ib_cond = ib_ctrl[g][CTRL_SEL_BIT] ? !ib_eq : ib_eq;
         assign ib_hit[g] = PC_VALID && ib_ctrl[g][CTRL_EN_BIT]
            && ib_ctrl[g][CTRL_THR_LSB + PC_THREAD] && ib_cond;
         // Loads only count when the load option is set
         wire dw_kind = !MEM_LOAD || dw_ctrl[g][CTRL_LOAD_BIT];
         wire dw_a = (MEM_ADDR == dw_addr_a[g]);
         wire dw_b = (MEM_ADDR == dw_addr_b[g]);
         wire dw_cond = dw_ctrl[g][CTRL_SEL_BIT] ? (dw_a || dw_b) : (dw_a && dw_b);
         assign dw_hit[g] = MEM_VALID && dw_kind && dw_ctrl[g][CTRL_EN_BIT]
            && dw_ctrl[g][CTRL_THR_LSB + MEM_THREAD] && dw_cond;
         // Condition B taken as the inverse of A
         wire rw_a = ((RES_ID & rw_mask[g]) == rw_value[g]);
         wire rw_cond = rw_ctrl[g][CTRL_SEL_BIT] ? !rw_a : rw_a;
         assign rw_hit[g] = RES_VALID && rw_ctrl[g][CTRL_EN_BIT]
            && rw_ctrl[g][CTRL_THR_LSB + RES_THREAD] && rw_cond;
      end
   endgenerate

   // ==========================================================
   // Lowest firing index
   function automatic logic [1:0] lowest(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      if (v[0]) r = 2'h0;
      else if (v[1]) r = 2'h1;
      else if (v[2]) r = 2'h2;
      else if (v[3]) r = 2'h3;
      return r;
   endfunction

   // Instruction breaks win over data, data over resource
   wire any_ib = |ib_hit;
   wire any_dw = |dw_hit;
   wire any_rw = |rw_hit;
   wire any_hit = any_ib || any_dw || any_rw;
   wire [31:0] next_type = any_ib ? {14'h0, lowest(ib_hit), 5'h0, PC_THREAD, 5'h0, CAUSE_IBRK}
      : any_dw ? {14'h0, lowest(dw_hit), 5'h0, MEM_THREAD, 5'h0, CAUSE_DW}
      : {14'h0, lowest(rw_hit), 5'h0, RES_THREAD, 5'h0, CAUSE_RW};
   wire [31:0] next_data = any_dw && !any_ib ? MEM_ADDR
      : (any_rw && !any_ib) ? RES_ID : int_data;

   // ==========================================================
   // Register decode
   wire [1:0] idx = REG_ADDR[1:0];
   wire hi_ok = (REG_ADDR[7:2] != 6'h0);
   wire wr_ib_t = REG_WR && (REG_ADDR[7:2] == REG_IBRK_TARGET[7:2]);
   wire wr_ib_c = REG_WR && (REG_ADDR[7:2] == REG_IBRK_CTRL[7:2]);
   wire wr_dw_a = REG_WR && (REG_ADDR[7:2] == REG_DW_ADDR_A[7:2]);
   wire wr_dw_b = REG_WR && (REG_ADDR[7:2] == REG_DW_ADDR_B[7:2]);
   wire wr_dw_c = REG_WR && (REG_ADDR[7:2] == REG_DW_CTRL[7:2]);
   wire wr_rw_m = REG_WR && (REG_ADDR[7:2] == REG_RW_MASK[7:2]);
   wire wr_rw_v = REG_WR && (REG_ADDR[7:2] == REG_RW_VALUE[7:2]);
   wire wr_rw_c = REG_WR && (REG_ADDR[7:2] == REG_RW_CTRL[7:2]);
   wire wr_stat = REG_WR && (REG_ADDR == REG_IRQ_STATUS);
   wire wr_mask = REG_WR && (REG_ADDR == REG_IRQ_MASK);
   wire [2:0] ev = {any_rw, any_dw, any_ib};

   // Config register writes; controls clear on reset
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         for (int i = 0; i < 4; i++) begin
            ib_ctrl[i] <= CTRL_RESET;
            dw_ctrl[i] <= CTRL_RESET;
            rw_ctrl[i] <= CTRL_RESET;
         end
      end else begin
         if (wr_ib_c) ib_ctrl[idx] <= REG_WDATA & IB_CTRL_MASK;
         if (wr_dw_c) dw_ctrl[idx] <= REG_WDATA & DW_CTRL_MASK;
         if (wr_rw_c) rw_ctrl[idx] <= REG_WDATA & RW_CTRL_MASK;
      end
   end

   // Address and value registers, no reset needed
   always_ff @(posedge SYS_CLK) begin
      if (wr_ib_t) ib_target[idx] <= REG_WDATA;
      if (wr_dw_a) dw_addr_a[idx] <= REG_WDATA;
      if (wr_dw_b) dw_addr_b[idx] <= REG_WDATA;
      if (wr_rw_m) rw_mask[idx] <= REG_WDATA;
      if (wr_rw_v) rw_value[idx] <= REG_WDATA;
   end

   // Cause capture and sticky status; event set beats a clear
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         int_type <= 32'h0;
         int_data <= 32'h0;
         irq_status <= 3'h0;
         irq_mask <= 3'h0;
      end else begin
         if (any_hit) begin
            int_type <= next_type;
            int_data <= next_data;
         end
         irq_status <= (irq_status & ~(wr_stat ? REG_WDATA[2:0] : 3'h0)) | ev;
         if (wr_mask) irq_mask <= REG_WDATA[2:0];
      end
   end

   // ==========================================================
   // Read mux; unmapped indices read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (REG_ADDR[7:2] == REG_IBRK_TARGET[7:2]) rd_mux = ib_target[idx];
      if (REG_ADDR[7:2] == REG_IBRK_CTRL[7:2]) rd_mux = ib_ctrl[idx];
      if (REG_ADDR[7:2] == REG_DW_ADDR_A[7:2]) rd_mux = dw_addr_a[idx];
      if (REG_ADDR[7:2] == REG_DW_ADDR_B[7:2]) rd_mux = dw_addr_b[idx];
      if (REG_ADDR[7:2] == REG_DW_CTRL[7:2]) rd_mux = dw_ctrl[idx];
      if (REG_ADDR[7:2] == REG_RW_MASK[7:2]) rd_mux = rw_mask[idx];
      if (REG_ADDR[7:2] == REG_RW_VALUE[7:2]) rd_mux = rw_value[idx];
      if (REG_ADDR[7:2] == REG_RW_CTRL[7:2]) rd_mux = rw_ctrl[idx];
      if (REG_ADDR == REG_INT_TYPE) rd_mux = int_type;
      if (REG_ADDR == REG_INT_DATA) rd_mux = int_data;
      if (REG_ADDR == REG_IRQ_STATUS) rd_mux = {29'h0, irq_status};
      if (REG_ADDR == REG_IRQ_MASK) rd_mux = {29'h0, irq_mask};
      if (!hi_ok && REG_ADDR != REG_INT_TYPE) rd_mux = 32'h0;
   end

   // Read data registered, valid only the cycle after the strobe
   always_ff @(posedge SYS_CLK) begin
      if (RESET) REG_RDATA <= 32'h0;
      else REG_RDATA <= REG_RD ? rd_mux : 32'h0;
   end

   assign DEBUG_IRQ = |(irq_status & irq_mask);

   // ==========================================================
   // Assertions
   property p_ib_fire;
      @(posedge SYS_CLK) disable iff (RESET)
      ib_hit[0] |=> int_type[2:0] == CAUSE_IBRK && int_type[17:16] == 2'h0;
   endproperty
   a_ib_fire: assert property (p_ib_fire) else $error("instr cause wrong");
   property p_ib_en;
      @(posedge SYS_CLK) disable iff (RESET)
      !ib_ctrl[1][CTRL_EN_BIT] |-> !ib_hit[1];
   endproperty
   a_ib_en: assert property (p_ib_en) else $error("disabled breakpoint fired");
   property p_ib_ne;
      @(posedge SYS_CLK) disable iff (RESET)
      ib_hit[2] && ib_ctrl[2][CTRL_SEL_BIT] |-> PC != ib_target[2];
   endproperty
   a_ib_ne: assert property (p_ib_ne) else $error("inequality break wrong");
   property p_thr;
      @(posedge SYS_CLK) disable iff (RESET)
      dw_hit[1] |-> dw_ctrl[1][CTRL_THR_LSB + MEM_THREAD];
   endproperty
   a_thr: assert property (p_thr) else $error("thread not enabled");
   property p_load;
      @(posedge SYS_CLK) disable iff (RESET)
      MEM_LOAD && !dw_ctrl[1][CTRL_LOAD_BIT] |-> !dw_hit[1];
   endproperty
   a_load: assert property (p_load) else $error("load hit without option");
   property p_and;
      @(posedge SYS_CLK) disable iff (RESET)
      dw_hit[1] && !dw_ctrl[1][CTRL_SEL_BIT] |-> MEM_ADDR == dw_addr_a[1]
         && MEM_ADDR == dw_addr_b[1];
   endproperty
   a_and: assert property (p_and) else $error("and combine wrong");
   property p_dw_data;
      @(posedge SYS_CLK) disable iff (RESET)
      any_dw && !any_ib |=> int_data == $past(MEM_ADDR) && int_type[2:0] == CAUSE_DW;
   endproperty
   a_dw_data: assert property (p_dw_data) else $error("data address not captured");
   property p_rw;
      @(posedge SYS_CLK) disable iff (RESET)
      rw_hit[3] && !rw_ctrl[3][CTRL_SEL_BIT] |-> (RES_ID & rw_mask[3]) == rw_value[3];
   endproperty
   a_rw: assert property (p_rw) else $error("resource compare wrong");
   property p_rst;
      @(posedge SYS_CLK) $fell(RESET) |-> ib_ctrl[0] == 32'h0 && dw_ctrl[0] == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("control not cleared");
   property p_irq;
      @(posedge SYS_CLK) disable iff (RESET)
      any_ib && irq_mask[IRQ_IBRK_BIT] |=> DEBUG_IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
   // Comparator checks on the indices that the scenarios use
   property p_ib_eq;
      @(posedge SYS_CLK) disable iff (RESET)
      ib_hit[2] && !ib_ctrl[2][CTRL_SEL_BIT] |-> PC == ib_target[2];
   endproperty
   a_ib_eq: assert property (p_ib_eq) else $error("equality break wrong");
   property p_ib_thr;
      @(posedge SYS_CLK) disable iff (RESET)
      ib_hit[0] |-> ib_ctrl[0][CTRL_THR_LSB + PC_THREAD];
   endproperty
   a_ib_thr: assert property (p_ib_thr) else $error("breakpoint thread not enabled");
   property p_rw_thr;
      @(posedge SYS_CLK) disable iff (RESET)
      rw_hit[3] |-> rw_ctrl[3][CTRL_THR_LSB + RES_THREAD];
   endproperty
   a_rw_thr: assert property (p_rw_thr) else $error("resource thread not enabled");
   property p_dw_en;
      @(posedge SYS_CLK) disable iff (RESET)
      !dw_ctrl[1][CTRL_EN_BIT] |-> !dw_hit[1];
   endproperty
   a_dw_en: assert property (p_dw_en) else $error("disabled watchpoint fired");
   property p_or;
      @(posedge SYS_CLK) disable iff (RESET)
      dw_hit[1] && dw_ctrl[1][CTRL_SEL_BIT]
         |-> MEM_ADDR == dw_addr_a[1] || MEM_ADDR == dw_addr_b[1];
   endproperty
   a_or: assert property (p_or) else $error("or combine wrong");
   property p_rw_en;
      @(posedge SYS_CLK) disable iff (RESET)
      !rw_ctrl[3][CTRL_EN_BIT] |-> !rw_hit[3];
   endproperty
   a_rw_en: assert property (p_rw_en) else $error("disabled resource watch fired");
   property p_rw_inv;
      @(posedge SYS_CLK) disable iff (RESET)
      rw_hit[3] && rw_ctrl[3][CTRL_SEL_BIT] |-> (RES_ID & rw_mask[3]) != rw_value[3];
   endproperty
   a_rw_inv: assert property (p_rw_inv) else $error("condition b wrong");
   // Cause word contents one cycle after a hit, and controls cleared at reset
   property p_ib_thread;
      @(posedge SYS_CLK) disable iff (RESET)
      any_ib |=> int_type[15:8] == {5'h0, $past(PC_THREAD)};
   endproperty
   a_ib_thread: assert property (p_ib_thread) else $error("instr thread wrong");
   property p_dw_thread;
      @(posedge SYS_CLK) disable iff (RESET)
      any_dw && !any_ib |=> int_type[15:8] == {5'h0, $past(MEM_THREAD)};
   endproperty
   a_dw_thread: assert property (p_dw_thread) else $error("data thread wrong");
   property p_dw_idx;
      @(posedge SYS_CLK) disable iff (RESET)
      dw_hit[1] && !dw_hit[0] && !any_ib |=> int_type[17:16] == 2'h1;
   endproperty
   a_dw_idx: assert property (p_dw_idx) else $error("data index wrong");
   property p_rw_idx;
      @(posedge SYS_CLK) disable iff (RESET)
      rw_hit[3] && rw_hit[2:0] == 3'h0 && !any_dw && !any_ib
         |=> int_type[17:16] == 2'h3;
   endproperty
   a_rw_idx: assert property (p_rw_idx) else $error("resource index wrong");
   property p_rw_data;
      @(posedge SYS_CLK) disable iff (RESET)
      any_rw && !any_dw && !any_ib
         |=> int_data == $past(RES_ID) && int_type[2:0] == CAUSE_RW;
   endproperty
   a_rw_data: assert property (p_rw_data) else $error("resource id not captured");
   property p_rst_all;
      @(posedge SYS_CLK)
      $fell(RESET) |-> ib_ctrl[3] == 32'h0 && dw_ctrl[3] == 32'h0 && rw_ctrl[3] == 32'h0;
   endproperty
   a_rst_all: assert property (p_rst_all) else $error("last control not cleared");
   // Status bits and interrupt level
   property p_ib_status;
      @(posedge SYS_CLK) disable iff (RESET)
      any_ib |=> irq_status[IRQ_IBRK_BIT];
   endproperty
   a_ib_status: assert property (p_ib_status) else $error("instr status not set");
   property p_dw_status;
      @(posedge SYS_CLK) disable iff (RESET)
      any_dw |=> irq_status[IRQ_DW_BIT];
   endproperty
   a_dw_status: assert property (p_dw_status) else $error("data status not set");
   property p_rw_status;
      @(posedge SYS_CLK) disable iff (RESET)
      any_rw |=> irq_status[IRQ_RW_BIT];
   endproperty
   a_rw_status: assert property (p_rw_status) else $error("resource status not set");
   property p_sticky;
      @(posedge SYS_CLK) disable iff (RESET)
      irq_status[IRQ_DW_BIT] && !(wr_stat && REG_WDATA[IRQ_DW_BIT])
         |=> irq_status[IRQ_DW_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit lost");
   property p_irq_rw;
      @(posedge SYS_CLK) disable iff (RESET)
      any_rw && irq_mask[IRQ_RW_BIT] && !wr_mask |=> DEBUG_IRQ;
   endproperty
   a_irq_rw: assert property (p_irq_rw) else $error("resource irq not raised");
   property p_irq_off;
      @(posedge SYS_CLK) disable iff (RESET)
      irq_mask == 3'h0 |-> !DEBUG_IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("masked irq raised");
   // Cover points for the main scenarios
   c_ib: cover property (@(posedge SYS_CLK) any_ib);
   c_dw: cover property (@(posedge SYS_CLK) any_dw && !any_ib);
   c_rw: cover property (@(posedge SYS_CLK) any_rw && !any_dw && !any_ib);
   c_and: cover property (@(posedge SYS_CLK) dw_hit[1] && !dw_ctrl[1][CTRL_SEL_BIT]);
   c_irq: cover property (@(posedge SYS_CLK) DEBUG_IRQ);
endmodule

// ===== hbwu_pipe.sv
// Pipeline model: issues instructions, memory and resource accesses.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/100ps
module hbwu_pipe
   import hbwu_pkg::*;
(
   input wire logic SYS_CLK, // Core clock
   output logic PC_VALID, // Instruction issued
   output logic [31:0] PC, // Program counter
   output logic [2:0] PC_THREAD, // Issuing thread
   output logic MEM_VALID, // Memory access
   output logic MEM_LOAD, // Access is a load
   output logic [31:0] MEM_ADDR, // Effective address
   output logic [2:0] MEM_THREAD, // Accessing thread
   output logic RES_VALID, // Resource access
   output logic [31:0] RES_ID, // Resource identifier
   output logic [2:0] RES_THREAD // Accessing thread
);
   // ==========================================
   // Idle fields start at zero, then show inverted data after each access, so stale values never match
   initial begin
      {PC_VALID, PC, PC_THREAD} = '0;
      {MEM_VALID, MEM_LOAD, MEM_ADDR, MEM_THREAD} = '0;
      {RES_VALID, RES_ID, RES_THREAD} = '0;
   end
   task automatic pc_go(input logic [31:0] a, input logic [2:0] t);
      @(posedge SYS_CLK);
      {PC_VALID, PC, PC_THREAD} <= {1'b1, a, t};
      @(posedge SYS_CLK);
      {PC_VALID, PC, PC_THREAD} <= {1'b0, ~a, ~t};
   endtask
   task automatic mem_go(input logic [31:0] a, input logic ld, input logic [2:0] t);
      @(posedge SYS_CLK);
      {MEM_VALID, MEM_LOAD, MEM_ADDR, MEM_THREAD} <= {1'b1, ld, a, t};
      @(posedge SYS_CLK);
      {MEM_VALID, MEM_LOAD, MEM_ADDR, MEM_THREAD} <= {1'b0, ~ld, ~a, ~t};
   endtask
   task automatic res_go(input logic [31:0] a, input logic [2:0] t);
      @(posedge SYS_CLK);
      {RES_VALID, RES_ID, RES_THREAD} <= {1'b1, a, t};
      @(posedge SYS_CLK);
      {RES_VALID, RES_ID, RES_THREAD} <= {1'b0, ~a, ~t};
   endtask
endmodule

// ===== tb.sv
// Testbench: register tasks plus pipeline model drive the match unit.
// Assumes the register port answers a read in the following cycle.
`timescale 1ns/100ps
module tb
   import hbwu_pkg::*;
;
   logic SYS_CLK = 1'b0;
   logic RESET = 1'b1;
   logic [7:0] REG_ADDR = '0;
   logic [31:0] REG_WDATA = '0;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   logic PC_VALID, MEM_VALID, MEM_LOAD, RES_VALID, DEBUG_IRQ;
   logic [31:0] PC, MEM_ADDR, RES_ID;
   logic [2:0] PC_THREAD, MEM_THREAD, RES_THREAD;
   int miscompares = 0;
   int n_checks = 0;
   // ==========================================
   // Clock, design and pipeline model
   always #2 SYS_CLK = ~SYS_CLK;
   hbwu_top dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .PC_VALID(PC_VALID), .PC(PC), .PC_THREAD(PC_THREAD), .MEM_VALID(MEM_VALID),
      .MEM_LOAD(MEM_LOAD), .MEM_ADDR(MEM_ADDR), .MEM_THREAD(MEM_THREAD),
      .RES_VALID(RES_VALID), .RES_ID(RES_ID), .RES_THREAD(RES_THREAD),
      .DEBUG_IRQ(DEBUG_IRQ));
   hbwu_pipe pipe (.SYS_CLK(SYS_CLK), .PC_VALID(PC_VALID), .PC(PC),
      .PC_THREAD(PC_THREAD), .MEM_VALID(MEM_VALID), .MEM_LOAD(MEM_LOAD),
      .MEM_ADDR(MEM_ADDR), .MEM_THREAD(MEM_THREAD), .RES_VALID(RES_VALID),
      .RES_ID(RES_ID), .RES_THREAD(RES_THREAD));
   // ==========================================
   // Register access and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge SYS_CLK);
      {REG_RD, REG_ADDR} <= {1'b1, a};
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk(REG_RDATA, e);
   endtask
   // Status, cause and IRQ after one event; clears status after
   task automatic hit(input logic [31:0] st, input logic [31:0] c, input logic irq);
      #1 chk({31'h0, DEBUG_IRQ}, {31'h0, irq});
      rc(REG_IRQ_STATUS, st);
      if (st != 0) rc(REG_INT_TYPE, c);
      wr(REG_IRQ_STATUS, 32'h7);
   endtask
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // Watchdog, far above the expected run
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      miscompares++;
      give_verdict();
   end
   // ==========================================
   // Test sequence
   initial begin
      repeat (2) @(posedge SYS_CLK);
      RESET <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rc(REG_IBRK_CTRL + 8'(i), CTRL_RESET);
         rc(REG_DW_CTRL + 8'(i), CTRL_RESET);
         rc(REG_RW_CTRL + 8'(i), CTRL_RESET);
      end
      rc(8'hff, 32'h0);
      wr(REG_IBRK_CTRL + 8'h1, '1);
      rc(REG_IBRK_CTRL + 8'h1, IB_CTRL_MASK);
      wr(REG_DW_CTRL + 8'h1, '1);
      rc(REG_DW_CTRL + 8'h1, DW_CTRL_MASK);
      wr(REG_RW_CTRL + 8'h1, '1);
      rc(REG_RW_CTRL + 8'h1, RW_CTRL_MASK);
      wr(REG_IBRK_CTRL + 8'h1, 32'h0);
      wr(REG_DW_CTRL + 8'h1, 32'h0);
      wr(REG_RW_CTRL + 8'h1, 32'h0);
      wr(REG_IRQ_MASK, 32'h7);
      $display("test reset and fields done");
      wr(REG_IBRK_TARGET + 8'h2, 32'h1000);
      rc(REG_IBRK_TARGET + 8'h2, 32'h1000);
      wr(REG_IBRK_CTRL + 8'h2, 32'h00200001);
      pipe.pc_go(32'h1000, 3'h4);
      hit(0, 0, 1'b0);
      pipe.pc_go(32'h1000, 3'h5);
      hit(1, 32'h00020503, 1'b1);
      wr(REG_IBRK_TARGET, 32'h1000);
      wr(REG_IBRK_CTRL, 32'h00200001);
      pipe.pc_go(32'h1000, 3'h5);
      hit(1, 32'h00000503, 1'b1);
      wr(REG_IBRK_CTRL, 32'h0);
      wr(REG_IBRK_CTRL + 8'h2, 32'h00200000);
      pipe.pc_go(32'h1000, 3'h5);
      hit(0, 0, 1'b0);
      wr(REG_IBRK_CTRL + 8'h2, 32'h00200003);
      pipe.pc_go(32'h1000, 3'h5);
      hit(0, 0, 1'b0);
      pipe.pc_go(32'h1004, 3'h5);
      hit(1, 32'h00020503, 1'b1);
      wr(REG_IBRK_CTRL + 8'h2, 32'h0);
      $display("test instruction breakpoints done");
      wr(REG_DW_ADDR_A + 8'h1, 32'h200);
      wr(REG_DW_ADDR_B + 8'h1, 32'h300);
      rc(REG_DW_ADDR_A + 8'h1, 32'h200);
      rc(REG_DW_ADDR_B + 8'h1, 32'h300);
      wr(REG_DW_CTRL + 8'h1, 32'h00010001);
      pipe.mem_go(32'h200, 1'b0, 3'h0);
      hit(0, 0, 1'b0);
      wr(REG_DW_CTRL + 8'h1, 32'h00010003);
      pipe.mem_go(32'h200, 1'b0, 3'h0);
      hit(2, 32'h00010004, 1'b1);
      rc(REG_INT_DATA, 32'h200);
      pipe.mem_go(32'h300, 1'b1, 3'h0);
      hit(0, 0, 1'b0);
      wr(REG_DW_CTRL + 8'h1, 32'h00010007);
      pipe.mem_go(32'h300, 1'b1, 3'h0);
      hit(2, 32'h00010004, 1'b1);
      rc(REG_INT_DATA, 32'h300);
      // Both conditions true at once: the and combine must fire
      wr(REG_DW_ADDR_B + 8'h1, 32'h200);
      wr(REG_DW_CTRL + 8'h1, 32'h00010001);
      pipe.mem_go(32'h200, 1'b0, 3'h0);
      hit(2, 32'h00010004, 1'b1);
      rc(REG_INT_DATA, 32'h200);
      wr(REG_DW_CTRL + 8'h1, 32'h0);
      $display("test data watchpoints done");
      wr(REG_RW_MASK + 8'h3, 32'hff00);
      wr(REG_RW_VALUE + 8'h3, 32'h1200);
      rc(REG_RW_MASK + 8'h3, 32'hff00);
      rc(REG_RW_VALUE + 8'h3, 32'h1200);
      wr(REG_RW_CTRL + 8'h3, 32'h00800001);
      pipe.res_go(32'h12ab, 3'h7);
      hit(4, 32'h00030705, 1'b1);
      rc(REG_INT_DATA, 32'h12ab);
      pipe.res_go(32'h13ab, 3'h7);
      hit(0, 0, 1'b0);
      wr(REG_RW_CTRL + 8'h3, 32'h00800003);
      pipe.res_go(32'h12ab, 3'h7);
      hit(0, 0, 1'b0);
      pipe.res_go(32'h13ab, 3'h7);
      hit(4, 32'h00030705, 1'b1);
      wr(REG_IRQ_MASK, 32'h0);
      pipe.res_go(32'h13ab, 3'h7);
      hit(4, 32'h00030705, 1'b0);
      $display("test resource watchpoints done");
      // Mid-run reset must return programmed controls to zero
      wr(REG_IBRK_CTRL + 8'h3, 32'h00ff0001);
      rc(REG_IBRK_CTRL + 8'h3, 32'h00ff0001);
      @(posedge SYS_CLK);
      RESET <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RESET <= 1'b0;
      rc(REG_IBRK_CTRL + 8'h3, CTRL_RESET);
      rc(REG_RW_CTRL + 8'h3, CTRL_RESET);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule
